// ---- drawer_cfg_host.sv ----
// host end: sequences port cycles from register commands
`timescale 1ns/1ps
`default_nettype none
module drawer_cfg_host
    import drawer_cfg_pkg::*;
(
    input  wire logic       clk_i,    // system clock
    input  wire logic       srst_i,   // sync reset
    input  wire logic [3:0] addr_i,   // register address
    input  wire logic [7:0] wdata_i,  // register write data
    input  wire logic       wr_i,     // write strobe
    input  wire logic       rd_i,     // read strobe
    output logic      [7:0] rdata_o,  // read data, cycle after rd_i
    io_port_if.host         io        // port cycles to device
);
    typedef enum {S_IDLE, S_STEP, S_CAPTURE} state_e;
    typedef struct packed {
        state_e     state;
        logic [3:0] step;
        logic [7:0] cmd;
        logic [7:0] base;
        logic [7:0] index;
        logic [7:0] wdat;
        logic [7:0] result;
        logic [7:0] rdata;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] pdata;
    } host_s;
    host_s st_r;
    host_s st_nxt;
    logic [7:0] seq_val;
    logic       seq_dat;
    logic       seq_last;
    logic [3:0] n_steps;

    // one fixed sequence: unlock, unlock, select ldn, target index, data, lock
    always_comb
    begin
        seq_dat = 1'b0;
        seq_val = UNLOCK_KEY;
        case (st_r.step)
            4'h0, 4'h1: seq_val = UNLOCK_KEY;
            4'h2: seq_val = IDX_LDN;
            4'h3: begin seq_dat = 1'b1; seq_val = LDN_DRAWER; end
            4'h4: seq_val = st_r.index;
            4'h5: begin seq_dat = 1'b1; seq_val = st_r.wdat; end
            default: seq_val = LOCK_KEY;
        endcase
    end
    assign n_steps  = 4'h6;
    assign seq_last = st_r.step == n_steps;

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.wr    = 1'b0;
        st_nxt.rd    = 1'b0;
        st_nxt.rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                HREG_STATUS: st_nxt.rdata = {7'h00, st_r.state != S_IDLE};
                HREG_RDATA:  st_nxt.rdata = st_r.result;
                HREG_BASE:   st_nxt.rdata = st_r.base;
                HREG_INDEX:  st_nxt.rdata = st_r.index;
                HREG_WDATA:  st_nxt.rdata = st_r.wdat;
                default:     st_nxt.rdata = 8'h00;
            endcase
        end
        if (wr_i && addr_i == HREG_BASE)
            st_nxt.base = wdata_i;
        if (wr_i && addr_i == HREG_INDEX)
            st_nxt.index = wdata_i;
        if (wr_i && addr_i == HREG_WDATA)
            st_nxt.wdat = wdata_i;
        case (st_r.state)
            S_IDLE:
            begin
                if (wr_i && addr_i == HREG_CMD && wdata_i != 8'h00)
                begin
                    st_nxt.cmd   = wdata_i;
                    st_nxt.step  = 4'h0;
                    st_nxt.state = S_STEP;
                    if (wdata_i == CMD_OPEN_ONE || wdata_i == CMD_OPEN_TWO || wdata_i == CMD_CLOSE)
                    begin
                        st_nxt.index = IDX_DRAWER_OUT;
                        st_nxt.wdat  = wdata_i == CMD_OPEN_ONE ? OPEN_ONE_VAL :
                                       wdata_i == CMD_OPEN_TWO ? OPEN_TWO_VAL : DRAWER_OUT_RST;
                    end
                end
            end
            S_STEP:
            begin
                st_nxt.addr  = seq_dat ? st_r.base + 8'h01 : st_r.base;
                st_nxt.pdata = seq_val;
                if (st_r.step == 4'h5 && st_r.cmd == CMD_READ)
                begin
                    st_nxt.rd    = 1'b1;
                    st_nxt.state = S_CAPTURE;
                end
                else
                begin
                    st_nxt.wr   = 1'b1;
                    st_nxt.step = st_r.step + 4'h1;
                    if (seq_last)
                        st_nxt.state = S_IDLE;
                end
            end
            S_CAPTURE:
            begin
                // rd pulse was this cycle; data returns next cycle
                if (!st_r.rd)
                begin
                    st_nxt.result = io.rdata;
                    st_nxt.step   = st_r.step + 4'h1;
                    st_nxt.state  = S_STEP;
                end
            end
            default: st_nxt.state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_r       <= '0;
            st_r.state <= S_IDLE;
            st_r.base  <= PORT_INDEX_A;
        end
        else
            st_r <= st_nxt;
    end

    assign rdata_o  = st_r.rdata;
    assign io.wr    = st_r.wr;
    assign io.rd    = st_r.rd;
    assign io.addr  = st_r.addr;
    assign io.wdata = st_r.pdata;
endmodule
`default_nettype wire

// ---- drawer_cfg_pkg.sv ----
// constants shared by both ends of the drawer configuration port
package drawer_cfg_pkg;
    localparam logic [7:0] PORT_INDEX_A   = 8'h2E;
    localparam logic [7:0] PORT_INDEX_B   = 8'h4E;
    localparam logic [7:0] UNLOCK_KEY     = 8'h87;
    localparam logic [7:0] LOCK_KEY       = 8'hAA;
    localparam logic [7:0] IDX_LDN        = 8'h07;
    localparam logic [7:0] LDN_DRAWER     = 8'h06;
    localparam logic [7:0] IDX_DRAWER_OUT = 8'h91;
    localparam logic [7:0] DRAWER_OUT_RST = 8'h00;
    localparam int         BIT_DRAWER_ONE = 2;
    localparam int         BIT_DRAWER_TWO = 3;
    localparam logic [7:0] OPEN_ONE_VAL   = 8'h04;
    localparam logic [7:0] OPEN_TWO_VAL   = 8'h08;
    localparam logic [7:0] PULSE_CODE_HI  = 8'h10;
    localparam logic [7:0] PULSE_CODE_LO  = 8'h14;
    // host-side register offsets
    localparam logic [3:0] HREG_CMD    = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h1;
    localparam logic [3:0] HREG_RDATA  = 4'h2;
    localparam logic [3:0] HREG_BASE   = 4'h3;
    localparam logic [3:0] HREG_INDEX  = 4'h4;
    localparam logic [3:0] HREG_WDATA  = 4'h5;
    // host command codes
    localparam logic [7:0] CMD_OPEN_ONE = 8'h01;
    localparam logic [7:0] CMD_OPEN_TWO = 8'h02;
    localparam logic [7:0] CMD_CLOSE    = 8'h03;
    localparam logic [7:0] CMD_WRITE    = 8'h04;
    localparam logic [7:0] CMD_READ     = 8'h05;
endpackage

// ---- io_port_if.sv ----
// host i/o port cycle interface between host and configuration device
`timescale 1ns/1ps
`default_nettype none
interface io_port_if;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport dev  (input wr, rd, addr, wdata, output rdata);
    modport host (output wr, rd, addr, wdata, input rdata);
endinterface
`default_nettype wire

// ---- cfg_key_detect.sv ----
// unlock and lock key detector for the function enable port
`timescale 1ns/1ps
`default_nettype none
module cfg_key_detect
    import drawer_cfg_pkg::*;
(
    input  wire logic clk_i,     // system clock
    input  wire logic srst_i,    // sync reset
    input  wire logic wr_i,      // write to function enable port
    input  wire logic [7:0] data_i, // written byte
    output logic      cfg_mode_o // configuration mode active
);
    typedef struct packed {
        logic seen_one;
        logic mode;
    } key_s;
    key_s st_r;
    key_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (wr_i)
        begin
            if (st_r.mode)
            begin
                if (data_i == LOCK_KEY)
                    st_nxt.mode = 1'b0;
                st_nxt.seen_one = 1'b0;
            end
            else if (data_i == UNLOCK_KEY)
            begin
                st_nxt.mode     = st_r.seen_one;
                st_nxt.seen_one = ~st_r.seen_one;
            end
            else
                st_nxt.seen_one = 1'b0;          // any other write breaks the pair
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign cfg_mode_o = st_r.mode;
endmodule
`default_nettype wire

// ---- drawer_cfg_dev.sv ----
// configuration device end: index/data port pair and drawer outputs
`timescale 1ns/1ps
`default_nettype none
module drawer_cfg_dev
    import drawer_cfg_pkg::*;
#(
    parameter logic [7:0] BASE = PORT_INDEX_A
)(
    input  wire logic clk_i,       // system clock
    input  wire logic srst_i,      // sync reset
    io_port_if.dev    io,          // host i/o cycles
    output logic      drawer_one_o, // drawer one open drive
    output logic      drawer_two_o, // drawer two open drive
    output logic      cfg_mode_o    // configuration mode flag
);
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] logical_device_number;
        logic [7:0] drawer_out;
        logic [7:0] rdata;
        logic       one;
        logic       two;
    } dev_s;
    dev_s st_r;
    dev_s st_nxt;
    logic mode;
    logic idx_hit;
    logic dat_hit;

    assign idx_hit = io.addr == BASE;
    assign dat_hit = io.addr == BASE + 8'h01;

    cfg_key_detect u_keys (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .wr_i       (io.wr && idx_hit),
        .data_i     (io.wdata),
        .cfg_mode_o (mode)
    );

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.rdata = 8'h00;
        if (mode && io.wr && idx_hit)
            st_nxt.index = io.wdata;
        if (mode && io.wr && dat_hit)
        begin
            if (st_r.index == IDX_LDN)
                st_nxt.logical_device_number = io.wdata;
            else if (st_r.logical_device_number == LDN_DRAWER && st_r.index == IDX_DRAWER_OUT)
                st_nxt.drawer_out = io.wdata;
        end
        if (mode && io.rd && dat_hit)
        begin
            if (st_r.index == IDX_LDN)
                st_nxt.rdata = st_r.logical_device_number;
            else if (st_r.logical_device_number == LDN_DRAWER && st_r.index == IDX_DRAWER_OUT)
                st_nxt.rdata = st_r.drawer_out;
        end
        st_nxt.one = st_nxt.drawer_out[BIT_DRAWER_ONE];
        st_nxt.two = st_nxt.drawer_out[BIT_DRAWER_TWO];
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_r            <= '0;
            st_r.drawer_out <= DRAWER_OUT_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign io.rdata     = st_r.rdata;
    assign drawer_one_o = st_r.one;
    assign drawer_two_o = st_r.two;
    assign cfg_mode_o   = mode;
endmodule
`default_nettype wire

// ---- drawer_cfg_monitor.sv ----
// checker on the port cycles and drawer outputs between host and device ends
`timescale 1ns/1ps
`default_nettype none
module drawer_cfg_monitor
    import drawer_cfg_pkg::*;
(
    input wire logic       clk_i,        // system clock
    input wire logic       srst_i,       // sync reset
    input wire logic       wr,           // port write
    input wire logic       rd,           // port read
    input wire logic [7:0] addr,         // port address
    input wire logic [7:0] wdata,        // port write data
    input wire logic [7:0] rdata,        // port read data
    input wire logic       cfg_mode_o,   // config mode flag
    input wire logic       drawer_one_o, // drawer one drive
    input wire logic       drawer_two_o  // drawer two drive
);
    logic [7:0] idx_r;
    logic [7:0] ldn_r;
    logic [7:0] drw_r;
    logic       key_w;
    logic       hit_w;
    // shadow of index, device number and drawer register, tracked from the wire
    assign key_w = wr && addr == PORT_INDEX_A && wdata == UNLOCK_KEY;
    assign hit_w = cfg_mode_o && addr == PORT_INDEX_A + 8'h01 && idx_r == IDX_DRAWER_OUT && ldn_r == LDN_DRAWER;
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            idx_r <= 8'h00;
            ldn_r <= 8'h00;
            drw_r <= DRAWER_OUT_RST;
        end
        else
        begin
            if (wr && cfg_mode_o && addr == PORT_INDEX_A && wdata != LOCK_KEY) idx_r <= wdata;
            if (wr && cfg_mode_o && addr == PORT_INDEX_A + 8'h01 && idx_r == IDX_LDN) ldn_r <= wdata;
            if (wr && hit_w) drw_r <= wdata;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    unlock_enter_a: assert property (key_w && $past(key_w) && !cfg_mode_o |=> cfg_mode_o)
        else $error("unlock pair did not enter config mode");
    mode_cause_a: assert property ($rose(cfg_mode_o) |-> $past(key_w) && $past(key_w, 2))
        else $error("config mode entered without unlock pair");
    lock_exit_a: assert property (cfg_mode_o && wr && addr == PORT_INDEX_A && wdata == LOCK_KEY |=> !cfg_mode_o)
        else $error("lock key did not end config mode");
    locked_hold_a: assert property (!cfg_mode_o && wr |=> $stable({drawer_one_o, drawer_two_o}))
        else $error("write outside config mode changed drawers");
    drawer_write_a: assert property (wr && hit_w |=>
        drawer_one_o == $past(wdata[BIT_DRAWER_ONE]) && drawer_two_o == $past(wdata[BIT_DRAWER_TWO]))
        else $error("drawer outputs do not follow register write");
    drawer_cause_a: assert property (!$past(srst_i) &&
        ($changed(drawer_one_o) || $changed(drawer_two_o)) |-> $past(wr && hit_w))
        else $error("drawer output changed without register write");
    read_back_a: assert property (rd && hit_w |=> rdata == $past(drw_r))
        else $error("drawer register read back wrong");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read answer");
    port_decode_a: assert property (wr || rd |-> addr == PORT_INDEX_A || addr == PORT_INDEX_A + 8'h01)
        else $error("port cycle outside index and data ports");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench joining host and device ends over the port interface
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import drawer_cfg_pkg::*;
();
    logic       clk_i = 1'b0;
    logic       srst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic       drawer_one_o;
    logic       drawer_two_o;
    logic       cfg_mode_o;
    int         fail_count = 0;
    int         total_checks = 0;
    integer     seed = 32'h13ab;
    logic [7:0] v;
    logic [7:0] rb;
    io_port_if  io ();
    always #50 clk_i = ~clk_i;
    drawer_cfg_host i_drawer_cfg_host (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .io(io));
    drawer_cfg_dev i_drawer_cfg_dev (.clk_i(clk_i), .srst_i(srst_i), .io(io), .drawer_one_o(drawer_one_o),
        .drawer_two_o(drawer_two_o), .cfg_mode_o(cfg_mode_o));
    drawer_cfg_monitor i_drawer_cfg_monitor (.clk_i(clk_i), .srst_i(srst_i), .wr(io.wr), .rd(io.rd),
        .addr(io.addr), .wdata(io.wdata), .rdata(io.rdata), .cfg_mode_o(cfg_mode_o),
        .drawer_one_o(drawer_one_o), .drawer_two_o(drawer_two_o));
    function automatic logic [7:0] exp_drw(input logic [7:0] r);
        return {6'h00, r[BIT_DRAWER_TWO], r[BIT_DRAWER_ONE]};
    endfunction
    task automatic close_out();
        if (fail_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h01;
        for (int n = 0; n < 40 && s[0] !== 1'b0; n++) reg_rd(HREG_STATUS, s);
        chk("busy", 8'h00, {7'h00, s[0]});
    endtask
    task automatic run_cmd(input logic [7:0] c, input logic [7:0] idx, input logic [7:0] d);
        reg_wr(HREG_INDEX, idx);
        reg_wr(HREG_WDATA, d);
        reg_wr(HREG_CMD, c);
        wait_idle();
    endtask
    initial
    begin
        #2_000_000;
        fail_count++;
        close_out();
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        chk("drawers", exp_drw(DRAWER_OUT_RST), {6'h00, drawer_two_o, drawer_one_o});
        chk("pulse code high", 8'h10, PULSE_CODE_HI);
        chk("pulse code low", 8'h14, PULSE_CODE_LO);
        reg_rd(HREG_BASE, rb);
        chk("base", 8'h2E, rb);
        reg_wr(HREG_INDEX, 8'h3C);
        reg_wr(HREG_WDATA, 8'hC3);
        reg_rd(HREG_INDEX, rb);
        chk("index reg", 8'h3C, rb);
        reg_rd(HREG_WDATA, rb);
        chk("wdata reg", 8'hC3, rb);
        run_cmd(CMD_READ, IDX_DRAWER_OUT, 8'h00);
        reg_rd(HREG_RDATA, rb);
        chk("reset value", DRAWER_OUT_RST, rb);
        // three fixed drawer commands first, then random register values
        for (int i = 0; i < 11; i++)
        begin
            v = $random(seed);
            if (i < 3) v = (i == 0) ? OPEN_ONE_VAL : (i == 1) ? OPEN_TWO_VAL : 8'h00;
            run_cmd((i < 3) ? CMD_OPEN_ONE + 8'(i) : CMD_WRITE, IDX_DRAWER_OUT, v);
            chk("drawers", exp_drw(v), {6'h00, drawer_two_o, drawer_one_o});
            chk("mode", 8'h00, {7'h00, cfg_mode_o});
            run_cmd(CMD_READ, IDX_DRAWER_OUT, 8'h00);
            reg_rd(HREG_RDATA, rb);
            chk("readback", v, rb);
        end
        run_cmd(CMD_READ, 8'h55, 8'h00);
        reg_rd(HREG_RDATA, rb);
        chk("unmapped index", 8'h00, rb);
        run_cmd(CMD_WRITE, 8'h92, 8'hFF);
        reg_wr(4'hF, 8'hFF);
        chk("drawers", exp_drw(v), {6'h00, drawer_two_o, drawer_one_o});
        // a second command while busy must be dropped
        reg_wr(HREG_CMD, CMD_OPEN_ONE);
        reg_rd(HREG_STATUS, rb);
        chk("busy", 8'h01, {7'h00, rb[0]});
        reg_wr(HREG_CMD, CMD_CLOSE);
        wait_idle();
        chk("drawers", exp_drw(OPEN_ONE_VAL), {6'h00, drawer_two_o, drawer_one_o});
        close_out();
    end
endmodule
`default_nettype wire
